// ==== cmes_cfg.svh ====
// Offsets, field positions, reset values and timing counts for the escape block
`ifndef CMES_CFG_SVH
`define CMES_CFG_SVH
// ==========================================================
// Register indices (printed offsets are not multiples of four)
`define CMES_IDX_ESC_CHAR 4'h0
`define CMES_IDX_GUARD 4'h1
`define CMES_IDX_TIMEOUT 4'h2
`define CMES_IDX_CTRL 4'h3
`define CMES_IDX_STATUS 4'h4
`define CMES_IDX_ASSOC 4'h5
`define CMES_IDX_UPDATE 4'h6
`define CMES_IDX_CRC 4'h7
`define CMES_IDX_FW_VER 4'h8
`define CMES_IDX_HW_VER 4'h9
`define CMES_IDX_COMPAT 4'ha
`define CMES_IDX_TAU 4'hb
`define CMES_IDX_IMG_CHECK 4'hc
// ==========================================================
// Reset values and limits
`define CMES_ESC_RST 8'h2b
`define CMES_GUARD_RST 11'h3e8
`define CMES_GUARD_MIN 11'h002
`define CMES_GUARD_MAX 11'h6d3
`define CMES_TMO_RST 13'h0064
`define CMES_TMO_MIN 13'h0002
`define CMES_TMO_MAX 13'h1770
`define CMES_ASSOC_INIT 8'hff
`define CMES_UPD_NONE 8'hff
// ==========================================================
// Control register field positions
`define CMES_CTRL_EXIT 0
`define CMES_CTRL_CMD 1
`define CMES_CTRL_PSM 2
// ==========================================================
// Timing: ms tick from 100 MHz, 100 ms units
`define CMES_CLK_MHZ 100
`define CMES_TICK_US 1000
`define CMES_TICK_CYC (`CMES_CLK_MHZ * `CMES_TICK_US)
`define CMES_TMO_UNIT_MS 100
`define CMES_CRC_POLY 32'h04c11db7
`endif

// ==== cmes_escape.sv ====
// Command-mode escape detector, timeout and status register file
`timescale 1ns/1ns
`include "cmes_cfg.svh"
module cmes_escape
  import cmes_pkg::*;
#(
  parameter logic [7:0] DEV_TYPE = 8'h5a, // Arbitrary value
  parameter logic [7:0] HW_REV = 8'h01, // Arbitrary value
  parameter logic [19:0] FW_VER = 20'h00100, // Arbitrary value
  parameter logic [15:0] HW_COMPAT = 16'h0003, // Arbitrary value
  parameter int TICK_CYC = `CMES_TICK_CYC // Cycles per ms tick
)(
  input wire logic sys_clk_i,
  input wire logic rst_n_i,
  input wire logic [3:0] reg_addr_i,
  input wire logic [31:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  output logic [31:0] reg_rdata_o,
  input wire logic rx_valid_i,
  input wire logic [7:0] rx_byte_i,
  input wire logic cmd_valid_i,
  input wire logic [7:0] assoc_status_i,
  input wire logic assoc_status_we_i,
  input wire logic [7:0] update_result_i,
  input wire logic update_result_we_i,
  input wire logic [31:0] tau_timer_i,
  input wire logic tau_known_i,
  output logic cmd_mode_o,
  output logic apply_o,
  output logic [7:0] escape_char_o,
  output logic [10:0] guard_interval_o,
  output logic [12:0] cmd_timeout_o
);

  // ========================================================
  // Declarations
  cmes_state_t state_reg; // Detector state
  logic [31:0] tick_cnt_reg; // Prescaler for the ms tick
  logic tick; // One-cycle ms pulse
  logic [10:0] quiet_reg; // Ms of silence seen
  logic [1:0] esc_cnt_reg; // Escape chars counted
  logic [10:0] seq_ms_reg; // Ms since first escape char
  logic [12:0] tmo_ms_reg; // Ms within 100 ms unit
  logic [12:0] tmo_units_reg; // 100 ms units elapsed
  logic [7:0] esc_pend_reg; // Pending escape character
  logic [10:0] guard_pend_reg; // Pending guard interval
  logic [12:0] tmo_pend_reg; // Pending timeout
  logic [7:0] esc_live_reg; // Applied escape character
  logic [10:0] guard_live_reg; // Applied guard interval
  logic [12:0] tmo_live_reg; // Applied timeout
  logic psm_en_reg; // Power saving enable
  logic [7:0] assoc_reg; // Association status
  logic [7:0] update_reg; // Update result
  logic [15:0] img_compat_reg; // Last image compatibility offered
  logic img_ok_reg; // Image accepted flag
  logic wr_exit; // Software exit strobe
  logic timeout_hit; // Timeout expiry
  logic leave; // Leaving command mode
  logic guard_met; // Silence reached guard
  logic is_esc; // Received byte is escape char
  logic [31:0] crc_val; // Configuration CRC

  // ========================================================
  // CRC over a 32-bit word, used for the configuration check
  function automatic logic [31:0] crc32_word(input logic [31:0] crc,
                                             input logic [31:0] data);
    logic [31:0] c;
    c = crc;
    for (int i = 31; i >= 0; i--)
    begin
      if (c[31] ^ data[i])
        c = {c[30:0], 1'b0} ^ `CMES_CRC_POLY;
      else
        c = {c[30:0], 1'b0};
    end
    return c;
  endfunction

  // Clamp helpers keep settings inside their legal range
  function automatic logic [10:0] clamp_guard(input logic [10:0] v);
    if (v < `CMES_GUARD_MIN)
      return `CMES_GUARD_MIN;
    else if (v > `CMES_GUARD_MAX)
      return `CMES_GUARD_MAX;
    else
      return v;
  endfunction

  function automatic logic [12:0] clamp_tmo(input logic [12:0] v);
    if (v < `CMES_TMO_MIN)
      return `CMES_TMO_MIN;
    else if (v > `CMES_TMO_MAX)
      return `CMES_TMO_MAX;
    else
      return v;
  endfunction

  // ========================================================
  // Millisecond tick shared by all timers
  always_ff @(posedge sys_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      tick_cnt_reg <= 32'h0;
    else if (tick_cnt_reg == 32'(TICK_CYC - 1))
      tick_cnt_reg <= 32'h0;
    else
      tick_cnt_reg <= tick_cnt_reg + 32'h1;
  end
  assign tick = (tick_cnt_reg == 32'(TICK_CYC - 1));

  // ========================================================
  // Decodes
  assign is_esc = rx_valid_i && (rx_byte_i == esc_live_reg);
  assign guard_met = (quiet_reg >= guard_live_reg);
  assign wr_exit = reg_wr_i && (reg_addr_i == `CMES_IDX_CTRL) &&
                   reg_wdata_i[`CMES_CTRL_EXIT];
  assign timeout_hit = (state_reg == CMES_CMD) &&
                       (tmo_units_reg >= tmo_live_reg);
  assign leave = (state_reg == CMES_CMD) && (wr_exit || timeout_hit);

  // ========================================================
  // Silence counter: any byte restarts it
  always_ff @(posedge sys_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      quiet_reg <= 11'h0;
    else if (rx_valid_i)
      quiet_reg <= 11'h0;
    else if (tick && quiet_reg != 11'h7ff)
      quiet_reg <= quiet_reg + 11'h1;
  end

  // ========================================================
  // Sequence time since first escape char
  always_ff @(posedge sys_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      seq_ms_reg <= 11'h0;
    else if (state_reg == CMES_IDLE)
      seq_ms_reg <= 11'h0;
    else if (tick && seq_ms_reg != 11'h7ff)
      seq_ms_reg <= seq_ms_reg + 11'h1;
  end

  // ========================================================
  // Escape detector state machine
  always_ff @(posedge sys_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      state_reg <= CMES_IDLE;
      esc_cnt_reg <= 2'h0;
    end
    else
    begin
      case (state_reg)
        CMES_IDLE:
        begin
          // First char only counts after a full silent guard
          if (is_esc && guard_met)
          begin
            state_reg <= CMES_ARMED;
            esc_cnt_reg <= 2'h1;
          end
        end
        CMES_ARMED:
        begin
          if (seq_ms_reg >= guard_live_reg)
            state_reg <= CMES_IDLE;
          else if (rx_valid_i && !is_esc)
            state_reg <= CMES_IDLE;
          else if (is_esc)
          begin
            if (esc_cnt_reg == 2'h2)
              state_reg <= CMES_POST;
            esc_cnt_reg <= esc_cnt_reg + 2'h1;
          end
        end
        CMES_POST:
        begin
          // A fourth byte in the trailing guard spoils it
          if (rx_valid_i)
            state_reg <= CMES_IDLE;
          else if (guard_met)
            state_reg <= CMES_CMD;
        end
        CMES_CMD:
        begin
          if (leave)
            state_reg <= CMES_IDLE;
        end
        default:
          state_reg <= CMES_IDLE;
      endcase
    end
  end

  // ========================================================
  // Command-mode timeout, 100 ms units
  always_ff @(posedge sys_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      tmo_ms_reg <= 13'h0;
      tmo_units_reg <= 13'h0;
    end
    else if (state_reg != CMES_CMD || cmd_valid_i)
    begin
      tmo_ms_reg <= 13'h0;
      tmo_units_reg <= 13'h0;
    end
    else if (tick)
    begin
      if (tmo_ms_reg == 13'(`CMES_TMO_UNIT_MS - 1))
      begin
        tmo_ms_reg <= 13'h0;
        tmo_units_reg <= tmo_units_reg + 13'h1;
      end
      else
        tmo_ms_reg <= tmo_ms_reg + 13'h1;
    end
  end

  // ========================================================
  // Pending configuration written by software
  always_ff @(posedge sys_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      esc_pend_reg <= `CMES_ESC_RST;
      guard_pend_reg <= `CMES_GUARD_RST;
      tmo_pend_reg <= `CMES_TMO_RST;
      psm_en_reg <= 1'b0;
    end
    else if (reg_wr_i)
    begin
      case (reg_addr_i)
        `CMES_IDX_ESC_CHAR: esc_pend_reg <= reg_wdata_i[7:0];
        `CMES_IDX_GUARD:
          guard_pend_reg <= clamp_guard(reg_wdata_i[10:0]);
        `CMES_IDX_TIMEOUT:
          tmo_pend_reg <= clamp_tmo(reg_wdata_i[12:0]);
        `CMES_IDX_CTRL: psm_en_reg <= reg_wdata_i[`CMES_CTRL_PSM];
        default: ;
      endcase
    end
  end

  // ========================================================
  // Applied configuration: committed on any exit
  always_ff @(posedge sys_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      esc_live_reg <= `CMES_ESC_RST;
      guard_live_reg <= `CMES_GUARD_RST;
      tmo_live_reg <= `CMES_TMO_RST;
    end
    else if (leave)
    begin
      esc_live_reg <= esc_pend_reg;
      guard_live_reg <= guard_pend_reg;
      tmo_live_reg <= tmo_pend_reg;
    end
  end

  // Apply pulse for the rest of the device
  always_ff @(posedge sys_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      apply_o <= 1'b0;
    else
      apply_o <= leave;
  end

  // ========================================================
  // Status values from the device
  always_ff @(posedge sys_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      assoc_reg <= `CMES_ASSOC_INIT;
      update_reg <= `CMES_UPD_NONE;
    end
    else
    begin
      // Codes pass as given; the table is owned by the firmware
      if (assoc_status_we_i)
        assoc_reg <= assoc_status_i;
      if (update_result_we_i)
        update_reg <= update_result_i;
    end
  end

  // ========================================================
  // Image compatibility check
  always_ff @(posedge sys_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      img_compat_reg <= 16'h0;
      img_ok_reg <= 1'b0;
    end
    else if (reg_wr_i && reg_addr_i == `CMES_IDX_IMG_CHECK)
    begin
      img_compat_reg <= reg_wdata_i[15:0];
      img_ok_reg <= (reg_wdata_i[15:0] >= HW_COMPAT);
    end
  end

  // ========================================================
  // CRC over applied settings, combinational
  assign crc_val = crc32_word(crc32_word(32'hffffffff,
                   {13'h0, guard_live_reg, esc_live_reg}),
                   {19'h0, tmo_live_reg}) & 32'h0fffffff;

  // ========================================================
  // Read port: data one cycle after the strobe
  always_ff @(posedge sys_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      reg_rdata_o <= 32'h0;
    else if (reg_rd_i)
    begin
      case (reg_addr_i)
        `CMES_IDX_ESC_CHAR: reg_rdata_o <= {24'h0, esc_pend_reg};
        `CMES_IDX_GUARD: reg_rdata_o <= {21'h0, guard_pend_reg};
        `CMES_IDX_TIMEOUT: reg_rdata_o <= {19'h0, tmo_pend_reg};
        `CMES_IDX_CTRL:
          reg_rdata_o <= {29'h0, psm_en_reg, 2'b00};
        `CMES_IDX_STATUS:
          reg_rdata_o <= {26'h0, img_ok_reg, 1'b0, state_reg};
        `CMES_IDX_ASSOC: reg_rdata_o <= {24'h0, assoc_reg};
        `CMES_IDX_UPDATE: reg_rdata_o <= {24'h0, update_reg};
        `CMES_IDX_CRC: reg_rdata_o <= crc_val;
        `CMES_IDX_FW_VER: reg_rdata_o <= {12'h0, FW_VER};
        `CMES_IDX_HW_VER:
          reg_rdata_o <= {16'h0, DEV_TYPE, HW_REV};
        `CMES_IDX_COMPAT: reg_rdata_o <= {16'h0, HW_COMPAT};
        `CMES_IDX_TAU:
          // Empty value as zero when unknown or PSM off
          reg_rdata_o <= (psm_en_reg && tau_known_i) ?
                         tau_timer_i : 32'h0;
        `CMES_IDX_IMG_CHECK: reg_rdata_o <= {16'h0, img_compat_reg};
        default: reg_rdata_o <= 32'h0;
      endcase
    end
    else
      reg_rdata_o <= 32'h0;
  end

  // ========================================================
  // Outputs
  assign cmd_mode_o = (state_reg == CMES_CMD);
  assign escape_char_o = esc_live_reg;
  assign guard_interval_o = guard_live_reg;
  assign cmd_timeout_o = tmo_live_reg;

endmodule

// ==== cmes_escape_asserts.sv ====
// Port-level assertions for the command-mode escape block
`timescale 1ns/1ns
module cmes_escape_asserts #(
  parameter logic [7:0] DEV_TYPE = 8'h5a, // Arbitrary value
  parameter logic [7:0] HW_REV = 8'h01, // Arbitrary value
  parameter logic [19:0] FW_VER = 20'h00100 // Arbitrary value
)(
  input wire logic sys_clk_i,
  input wire logic rst_n_i,
  input wire logic [3:0] reg_addr_i,
  input wire logic [31:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  input wire logic [31:0] reg_rdata_o,
  input wire logic rx_valid_i,
  input wire logic tau_known_i,
  input wire logic cmd_mode_o,
  input wire logic apply_o,
  input wire logic [7:0] escape_char_o,
  input wire logic [10:0] guard_interval_o,
  input wire logic [12:0] cmd_timeout_o
);
  // ==========================================================
  // Single clock domain, so one clocking and one disable
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (!rst_n_i);
  chk_exit_write_leaves:
    assert property (cmd_mode_o && reg_wr_i && reg_addr_i == 4'h3
      && reg_wdata_i[0] |=> !cmd_mode_o && apply_o) else $error("no exit");
  chk_apply_one_cycle:
    assert property (apply_o |=> !apply_o) else $error("apply too long");
  chk_leave_applies:
    assert property ($fell(cmd_mode_o) |-> apply_o) else $error("no apply");
  chk_config_on_apply:
    assert property ($changed(escape_char_o) || $changed(guard_interval_o)
      || $changed(cmd_timeout_o) |-> apply_o) else $error("config moved");
  chk_rdata_idle_zero:
    assert property (!reg_rd_i |=> reg_rdata_o == 32'h0)
      else $error("rdata not zero");
  chk_entry_silence:
    assert property ($rose(cmd_mode_o) |-> !$past(rx_valid_i)
      && !$past(rx_valid_i, 2)) else $error("entry without silence");
  chk_hw_version_word:
    assert property (reg_rd_i && reg_addr_i == 4'h9 |=>
      reg_rdata_o == {16'h0, DEV_TYPE, HW_REV}) else $error("hw ver");
  chk_fw_version_word:
    assert property (reg_rd_i && reg_addr_i == 4'h8 |=>
      reg_rdata_o == {12'h0, FW_VER}) else $error("fw ver");
  chk_crc_top_zero:
    assert property (reg_rd_i && reg_addr_i == 4'h7 |=>
      reg_rdata_o[31:28] == 4'h0) else $error("crc width");
  chk_tau_unknown_empty:
    assert property (reg_rd_i && reg_addr_i == 4'hb && !tau_known_i |=>
      reg_rdata_o == 32'h0) else $error("tau not empty");
endmodule
bind cmes_escape cmes_escape_asserts #(.DEV_TYPE(DEV_TYPE),
  .HW_REV(HW_REV), .FW_VER(FW_VER)) u_chk (.sys_clk_i, .rst_n_i,
  .reg_addr_i, .reg_wdata_i, .reg_wr_i, .reg_rd_i, .reg_rdata_o,
  .rx_valid_i, .tau_known_i, .cmd_mode_o, .apply_o, .escape_char_o,
  .guard_interval_o, .cmd_timeout_o);

// ==== cmes_host_model.sv ====
// Host serial side: sends bursts of bytes two cycles apart
`timescale 1ns/1ns
module cmes_host_model (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic go_i,
  input wire logic [7:0] chr_i,
  input wire logic [1:0] n_i,
  output logic rx_valid_o,
  output logic [7:0] rx_byte_o
);
  logic [2:0] cnt_reg; // Half-slots left in the burst
  // ==========================================================
  // Burst sender; byte line toggles when not qualified so no stale match
  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      cnt_reg <= 3'h0;
      rx_valid_o <= 1'b0;
      rx_byte_o <= 8'h00;
    end
    else
    begin
      rx_valid_o <= 1'b0;
      rx_byte_o <= ~rx_byte_o;
      if (go_i)
        cnt_reg <= {n_i, 1'b0};
      else if (cnt_reg != 3'h0)
      begin
        cnt_reg <= cnt_reg - 3'h1;
        if (!cnt_reg[0])
        begin
          rx_valid_o <= 1'b1;
          rx_byte_o <= chr_i;
        end
      end
    end
  end
endmodule

// ==== cmes_pkg.sv ====
// Types shared by the escape block
package cmes_pkg;
  // Escape detector states
  typedef enum logic [3:0] {
    CMES_IDLE = 4'b0001,
    CMES_ARMED = 4'b0010,
    CMES_POST = 4'b0100,
    CMES_CMD = 4'b1000
  } cmes_state_t;
endpackage

// ==== testbench.sv ====
// Self-checking bench for the command-mode escape block
`timescale 1ns/1ns
module testbench;
  localparam int TICK = 10; // Short ms tick keeps the run small
  logic sys_clk = 1'b0, rst_n = 1'b0;
  logic [3:0] addr = 4'h0;
  logic [31:0] wdata = 32'h0, rdata, tau = 32'h00012345, d, crc0;
  logic wr = 1'b0, rd = 1'b0, cmdv = 1'b0, as_we = 1'b0, up_we = 1'b0;
  logic [7:0] as_v = 8'h00, up_v = 8'h00, chr = 8'h00, esc, rxb;
  logic tau_known = 1'b1, go = 1'b0, cmd_mode, apply, rxv;
  logic [1:0] n = 2'h0;
  logic [10:0] grd;
  logic [12:0] tmo;
  logic [7:0] ac [14] = '{8'h00, 8'h22, 8'h23, 8'h24, 8'h25, 8'h2a, 8'h2b,
    8'h2c, 8'h2d, 8'h2e, 8'h2f, 8'h30, 8'h31, 8'hff};
  logic [7:0] uc [8] = '{8'h00, 8'h01, 8'h02, 8'h10, 8'h11, 8'h12, 8'hfe,
    8'hff};
  int num_errors = 0, n_tests = 0;
  always #5 sys_clk = ~sys_clk;
  cmes_escape #(.TICK_CYC(TICK)) u_cmes_escape (.sys_clk_i(sys_clk),
    .rst_n_i(rst_n), .reg_addr_i(addr), .reg_wdata_i(wdata), .reg_wr_i(wr),
    .reg_rd_i(rd), .reg_rdata_o(rdata), .rx_valid_i(rxv), .rx_byte_i(rxb),
    .cmd_valid_i(cmdv), .assoc_status_i(as_v), .assoc_status_we_i(as_we),
    .update_result_i(up_v), .update_result_we_i(up_we), .tau_timer_i(tau),
    .tau_known_i(tau_known), .cmd_mode_o(cmd_mode), .apply_o(apply),
    .escape_char_o(esc), .guard_interval_o(grd), .cmd_timeout_o(tmo));
  cmes_host_model u_cmes_host_model (.clk_i(sys_clk), .rst_n_i(rst_n),
    .go_i(go), .chr_i(chr), .n_i(n), .rx_valid_o(rxv), .rx_byte_o(rxb));
  // ==========================================================
  // Shared bus, wait and compare tasks
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wr_reg(input logic [3:0] a, input logic [31:0] v);
    @(posedge sys_clk);
    addr <= a; wdata <= v; wr <= 1'b1;
    @(posedge sys_clk);
    wr <= 1'b0;
  endtask
  task automatic rd_reg(input logic [3:0] a, output logic [31:0] v);
    @(posedge sys_clk);
    addr <= a; rd <= 1'b1;
    @(posedge sys_clk);
    rd <= 1'b0;
    #1 v = rdata; // Read data stand only in this cycle
  endtask
  task automatic ms(input int k);
    repeat (k * TICK) @(posedge sys_clk);
    #1;
  endtask
  task automatic send(input logic [7:0] c, input logic [1:0] k);
    @(posedge sys_clk);
    chr <= c; n <= k; go <= 1'b1;
    @(posedge sys_clk);
    go <= 1'b0;
    repeat (8) @(posedge sys_clk);
  endtask
  // ==========================================================
  // Scenarios
  task automatic t_reset_values;
    rd_reg(4'h0, d); chk(d, 32'h2b);
    rd_reg(4'h1, d); chk(d, 32'h3e8);
    rd_reg(4'h2, d); chk(d, 32'h64);
    rd_reg(4'h5, d); chk(d, 32'hff);
    rd_reg(4'hb, d); chk(d, 32'h0);
    wr_reg(4'h9, 32'h0); rd_reg(4'h9, d); chk(d, 32'h5a01);
    rd_reg(4'h8, d); chk(d, 32'h00100);
    rd_reg(4'hd, d); chk(d, 32'h0);
    rd_reg(4'h6, d); chk(d, 32'hff);
    rd_reg(4'h4, d); chk(d, 32'h1);
    rd_reg(4'h7, crc0);
    chk({3'h0, cmd_mode, esc, 5'h0, grd}, {4'h0, 8'h2b, 5'h0, 11'h3e8});
    chk({apply, tmo}, {1'b0, 13'h64});
  endtask
  task automatic t_enter_default_and_exit;
    ms(1002); send(8'h2b, 2'h3);
    ms(996); chk(cmd_mode, 1'b0);
    ms(6); chk(cmd_mode, 1'b1);
    wr_reg(4'h1, 32'h1); rd_reg(4'h1, d); chk(d, 32'h2);
    wr_reg(4'h1, 32'h7ff); rd_reg(4'h1, d); chk(d, 32'h6d3);
    wr_reg(4'h2, 32'h0); rd_reg(4'h2, d); chk(d, 32'h2);
    wr_reg(4'h2, 32'h1fff); rd_reg(4'h2, d); chk(d, 32'h1770);
    wr_reg(4'h1, 32'h2); wr_reg(4'h2, 32'h2); wr_reg(4'h0, 32'h41);
    chk(esc, 8'h2b);
    wr_reg(4'h3, 32'h1);
    #1; // Apply pulse stands only in the cycle after the exit write
    chk({apply, cmd_mode}, 2'b10);
    chk({esc, grd, tmo}, {8'h41, 11'h2, 13'h2});
    rd_reg(4'h7, d); chk(d !== crc0, 1'b1);
  endtask
  task automatic t_guard_and_timeout;
    int i;
    ms(3); send(8'h2b, 2'h3); ms(3); chk(cmd_mode, 1'b0);
    ms(3); send(8'h41, 2'h3); send(8'h41, 2'h1);
    ms(3); chk(cmd_mode, 1'b0);
    ms(3); send(8'h41, 2'h3); ms(3); chk(cmd_mode, 1'b1);
    wr_reg(4'h0, 32'h2b); wr_reg(4'h3, 32'h4);
    ms(100);
    @(posedge sys_clk); cmdv <= 1'b1;
    @(posedge sys_clk); cmdv <= 1'b0;
    ms(150); chk(cmd_mode, 1'b1);
    i = 0;
    while (apply !== 1'b1 && i < 3000)
    begin
      @(posedge sys_clk); #1; i++;
    end
    chk({apply, cmd_mode, esc}, {2'b10, 8'h2b});
  endtask
  task automatic t_status;
    tau_known <= 1'b0; rd_reg(4'hb, d); chk(d, 32'h0);
    tau_known <= 1'b1; rd_reg(4'hb, d); chk(d, tau);
    foreach (ac[i])
    begin
      @(posedge sys_clk); as_v <= ac[i]; as_we <= 1'b1;
      @(posedge sys_clk); as_we <= 1'b0;
      rd_reg(4'h5, d); chk(d, {24'h0, ac[i]});
    end
    foreach (uc[i])
    begin
      @(posedge sys_clk); up_v <= uc[i]; up_we <= 1'b1;
      @(posedge sys_clk); up_we <= 1'b0;
      rd_reg(4'h6, d); chk(d, {24'h0, uc[i]});
    end
    rd_reg(4'ha, d); chk(d, 32'h3);
    wr_reg(4'hc, 32'h2); rd_reg(4'h4, d); chk(d[5], 1'b0);
    wr_reg(4'hc, 32'h3); rd_reg(4'h4, d); chk(d[5], 1'b1);
  endtask
  // ==========================================================
  // Verdict, watchdog and main sequence
  task automatic print_verdict;
    $display("Comparisons %0d, mismatches %0d", n_tests, num_errors);
    if (num_errors == 0 && n_tests > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  initial
  begin
    repeat (60000) @(posedge sys_clk); // About two and a half times the planned run
    num_errors++;
    print_verdict();
  end
  initial
  begin
    repeat (6) @(posedge sys_clk);
    rst_n <= 1'b1;
    t_reset_values();
    t_enter_default_and_exit();
    t_guard_and_timeout();
    t_status();
    print_verdict();
  end
endmodule
